/* fsb_pkg.sv */
// Shared types and constants for the flag, shift and I/O bit datapath.
// Assumes one core clock and a synchronous active-high reset.
package fsb_pkg;

  typedef enum logic [4:0] {
    OP_NONE                  = 5'h0_0,
    OP_SHIFT_LEFT_LOGICAL    = 5'h0_1,
    OP_ROTATE_LEFT_CARRY     = 5'h0_2,
    OP_SHIFT_RIGHT_LOGICAL   = 5'h0_3,
    OP_ROTATE_RIGHT_CARRY    = 5'h0_4,
    OP_SHIFT_RIGHT_ARITH     = 5'h0_5,
    OP_TRANSFER_BIT_STORE    = 5'h0_6,
    OP_TRANSFER_BIT_LOAD     = 5'h0_7,
    OP_FLAG_SET_INDEXED      = 5'h0_8,
    OP_FLAG_CLEAR_INDEXED    = 5'h0_9,
    OP_BRANCH_TRANSFER_CLEAR = 5'h0_A,
    OP_BRANCH_OVERFLOW_SET   = 5'h0_B,
    OP_BRANCH_OVERFLOW_CLEAR = 5'h0_C,
    OP_BRANCH_IRQ_ENABLED    = 5'h0_D,
    OP_BRANCH_IRQ_DISABLED   = 5'h0_E,
    OP_IO_BIT_SET            = 5'h0_F,
    OP_IO_BIT_CLEAR          = 5'h1_0,
    OP_SKIP_IF_IO_BIT_SET    = 5'h1_1,
    OP_SKIP_IF_IO_BIT_CLEAR  = 5'h1_2,
    OP_PORT_IN               = 5'h1_3,
    OP_PORT_OUT              = 5'h1_4,
    OP_LOAD_DATA             = 5'h1_5,
    OP_STORE_DATA            = 5'h1_6
  } op_t;

  // Flag positions inside the status flags register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0]  FLAGS_RESET     = 8'h0_0;
  localparam logic [7:0]  BIT_IO_LAST     = 8'h1_F;
  localparam logic [7:0]  PORT_IO_LAST    = 8'h3_F;
  localparam logic [15:0] IO_DATA_OFFSET  = 16'h0_020;
  localparam logic [15:0] EXT_IO_FIRST    = 16'h0_060;
  localparam logic [15:0] EXT_IO_LAST     = 16'h0_0FF;
  localparam logic [15:0] PC_STEP         = 16'h0_001;
  localparam int          IO_BIT_CYCLES   = 2;
  localparam int          BRANCH_TAKEN_CYCLES = 2;

  typedef struct packed {
    op_t         op;
    logic [7:0]  operand;
    logic [2:0]  bit_sel;
    logic [15:0] addr;
    logic [15:0] pc;
    logic signed [6:0] offset;
  } request_t;

  typedef struct packed {
    logic        io_rd;
    logic        io_wr;
    logic [5:0]  io_addr;
    logic [7:0]  io_wdata;
    logic        ext_rd;
    logic        ext_wr;
    logic [15:0] ext_addr;
    logic [7:0]  ext_wdata;
  } io_access_t;

endpackage : fsb_pkg

/* fsb_shifter.sv */
// Shift and rotate unit with its Z, C, N and V results.
// Assumes a combinational caller that registers the outputs.
`timescale 1ns/1ns
`default_nettype none
module fsb_shifter (
  input  wire fsb_pkg::op_t op,
  input  wire logic [7:0]   value,
  input  wire logic         carry_in,
  output logic [7:0]        result,
  output logic [3:0]        flags_out
);
  logic c;
  logic n;
  logic z;
  logic v;

  always_comb begin
    result = value;
    c      = carry_in;
    case (op)
      fsb_pkg::OP_SHIFT_LEFT_LOGICAL: begin
        result = {value[6:0], 1'b0};
        c      = value[7];
      end
      fsb_pkg::OP_ROTATE_LEFT_CARRY: begin
        result = {value[6:0], carry_in};
        c      = value[7];
      end
      fsb_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
        result = {1'b0, value[7:1]};
        c      = value[0];
      end
      fsb_pkg::OP_ROTATE_RIGHT_CARRY: begin
        result = {carry_in, value[7:1]};
        c      = value[0];
      end
      fsb_pkg::OP_SHIFT_RIGHT_ARITH: begin
        result = {value[7], value[7:1]};
        c      = value[0];
      end
      default: begin
        result = value;
        c      = carry_in;
      end
    endcase
    n = result[7];
    z = (result == 8'h0_0);
    // Every shift reports V as N xor C, which keeps the signed test consistent.
    v = n ^ c;
    flags_out = {v, n, z, c};
  end
endmodule : fsb_shifter
`default_nettype wire

/* fsb_io_map.sv */
// Address classifier for port, bit-access and extended I/O ranges.
// Assumes the caller gates the results with the operation kind.
`timescale 1ns/1ns
`default_nettype none
module fsb_io_map (
  input  wire logic [15:0] data_addr,
  input  wire logic [7:0]  port_addr,
  output logic             port_ok,
  output logic             bit_ok,
  output logic             data_is_io,
  output logic [5:0]       data_io_addr,
  output logic             data_is_ext
);
  logic [15:0] rel;

  always_comb begin
    rel          = data_addr - fsb_pkg::IO_DATA_OFFSET;
    port_ok      = (port_addr <= fsb_pkg::PORT_IO_LAST);
    bit_ok       = (port_addr <= fsb_pkg::BIT_IO_LAST);
    data_is_io   = (data_addr >= fsb_pkg::IO_DATA_OFFSET)
                 && (rel <= {8'h0_0, fsb_pkg::PORT_IO_LAST});
    data_io_addr = rel[5:0];
    data_is_ext  = (data_addr >= fsb_pkg::EXT_IO_FIRST)
                 && (data_addr <= fsb_pkg::EXT_IO_LAST);
  end
endmodule : fsb_io_map
`default_nettype wire

/* flag_shift_bitio_datapath.sv */
// Flag, shift, conditional branch and I/O bit datapath of an 8-bit core.
// Assumes decode presents one request at a time and waits for DONE.
`timescale 1ns/1ns
`default_nettype none
module flag_shift_bitio_datapath (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              REQ_VALID,
  input  wire fsb_pkg::request_t REQ,
  output logic                   REQ_READY,
  output logic                   DONE,
  output logic [7:0]             RESULT,
  output logic                   RESULT_VALID,
  output logic                   PC_LOAD,
  output logic [15:0]            PC_NEXT,
  output logic                   SKIP_NEXT,
  output logic                   ACCESS_ERROR,
  output logic [7:0]             STATUS_FLAGS,
  output fsb_pkg::io_access_t    IO_ACCESS,
  output logic [7:0]             IO_W1C_MASK,
  input  wire logic [7:0]        IO_RDATA,
  input  wire logic [7:0]        IO_CLEAR_ON_ONE
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_IO_RMW = 2'b01,
    ST_BRANCH = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t              phase;
    logic [7:0]          flags;
    logic                done;
    logic [7:0]          result;
    logic                result_valid;
    logic                pc_load;
    logic [15:0]         pc_next;
    logic                skip_next;
    logic                access_error;
    fsb_pkg::io_access_t io;
    logic [7:0]          w1c_mask;
    fsb_pkg::request_t   held;
  } state_t;

  state_t st;
  state_t next_st;

  logic [7:0] shift_result;
  logic [3:0] shift_flags;
  logic       port_ok;
  logic       bit_ok;
  logic       data_is_io;
  logic [5:0] data_io_addr;
  logic       data_is_ext;

  fsb_shifter u_shifter (
    .op        (REQ.op),
    .value     (REQ.operand),
    .carry_in  (st.flags[fsb_pkg::FLAG_C]),
    .result    (shift_result),
    .flags_out (shift_flags)
  );

  fsb_io_map u_io_map (
    .data_addr    (REQ.addr),
    .port_addr    (REQ.addr[7:0]),
    .port_ok      (port_ok),
    .bit_ok       (bit_ok),
    .data_is_io   (data_is_io),
    .data_io_addr (data_io_addr),
    .data_is_ext  (data_is_ext)
  );

  logic        take;
  logic        cond;
  logic        is_branch;
  logic [15:0] target;
  logic [7:0]  bit_mask;
  logic [7:0]  held_mask;

  always_comb begin
    next_st = st;
    next_st.done         = 1'b0;
    next_st.result_valid = 1'b0;
    next_st.pc_load      = 1'b0;
    next_st.skip_next    = 1'b0;
    next_st.access_error = 1'b0;
    next_st.io           = '0;
    next_st.w1c_mask     = 8'h0_0;
    take      = REQ_VALID && (st.phase == ST_IDLE);
    bit_mask  = 8'h0_1 << REQ.bit_sel;
    held_mask = 8'h0_1 << st.held.bit_sel;
    target    = REQ.pc + 16'(signed'(REQ.offset)) + fsb_pkg::PC_STEP;
    cond      = 1'b0;
    is_branch = 1'b0;
    case (REQ.op)
      fsb_pkg::OP_BRANCH_TRANSFER_CLEAR: begin
        is_branch = 1'b1;
        cond      = !st.flags[fsb_pkg::FLAG_T];
      end
      fsb_pkg::OP_BRANCH_OVERFLOW_SET: begin
        is_branch = 1'b1;
        cond      = st.flags[fsb_pkg::FLAG_V];
      end
      fsb_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
        is_branch = 1'b1;
        cond      = !st.flags[fsb_pkg::FLAG_V];
      end
      fsb_pkg::OP_BRANCH_IRQ_ENABLED: begin
        is_branch = 1'b1;
        cond      = st.flags[fsb_pkg::FLAG_I];
      end
      fsb_pkg::OP_BRANCH_IRQ_DISABLED: begin
        is_branch = 1'b1;
        cond      = !st.flags[fsb_pkg::FLAG_I];
      end
      default: begin
        is_branch = 1'b0;
        cond      = 1'b0;
      end
    endcase

    case (st.phase)
      ST_IDLE: begin
        if (take) begin
          next_st.held = REQ;
          next_st.done = 1'b1;
          if (is_branch) begin
            if (cond) begin
              // A taken branch holds one extra cycle before the target load.
              next_st.done    = 1'b0;
              next_st.pc_next = target;
              next_st.phase   = ST_BRANCH;
            end
          end else begin
            case (REQ.op)
              fsb_pkg::OP_SHIFT_LEFT_LOGICAL,
              fsb_pkg::OP_ROTATE_LEFT_CARRY,
              fsb_pkg::OP_SHIFT_RIGHT_LOGICAL,
              fsb_pkg::OP_ROTATE_RIGHT_CARRY,
              fsb_pkg::OP_SHIFT_RIGHT_ARITH: begin
                next_st.result       = shift_result;
                next_st.result_valid = 1'b1;
                // Shifts leave S and H alone; only Z, C, N and V follow the result.
                next_st.flags[fsb_pkg::FLAG_C] = shift_flags[0];
                next_st.flags[fsb_pkg::FLAG_Z] = shift_flags[1];
                next_st.flags[fsb_pkg::FLAG_N] = shift_flags[2];
                next_st.flags[fsb_pkg::FLAG_V] = shift_flags[3];
              end
              fsb_pkg::OP_TRANSFER_BIT_STORE: begin
                next_st.flags[fsb_pkg::FLAG_T] = REQ.operand[REQ.bit_sel];
              end
              fsb_pkg::OP_TRANSFER_BIT_LOAD: begin
                next_st.result = REQ.operand;
                next_st.result[REQ.bit_sel] = st.flags[fsb_pkg::FLAG_T];
                next_st.result_valid = 1'b1;
              end
              fsb_pkg::OP_FLAG_SET_INDEXED: begin
                next_st.flags[REQ.bit_sel] = 1'b1;
              end
              fsb_pkg::OP_FLAG_CLEAR_INDEXED: begin
                next_st.flags[REQ.bit_sel] = 1'b0;
              end
              fsb_pkg::OP_IO_BIT_SET,
              fsb_pkg::OP_IO_BIT_CLEAR: begin
                if (bit_ok) begin
                  // Read first; the write goes out in the second cycle.
                  next_st.done        = 1'b0;
                  next_st.io.io_rd    = 1'b1;
                  next_st.io.io_addr  = REQ.addr[5:0];
                  next_st.phase       = ST_IO_RMW;
                end else begin
                  next_st.access_error = 1'b1;
                end
              end
              fsb_pkg::OP_SKIP_IF_IO_BIT_SET,
              fsb_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
                // The tested register value is sampled in this same cycle.
                if (bit_ok) begin
                  next_st.io.io_rd   = 1'b1;
                  next_st.io.io_addr = REQ.addr[5:0];
                  next_st.skip_next  = ((IO_RDATA & bit_mask) != 8'h0_0)
                    == (REQ.op == fsb_pkg::OP_SKIP_IF_IO_BIT_SET);
                end else begin
                  next_st.access_error = 1'b1;
                end
              end
              fsb_pkg::OP_PORT_IN,
              fsb_pkg::OP_PORT_OUT: begin
                if (port_ok) begin
                  next_st.io.io_addr  = REQ.addr[5:0];
                  next_st.io.io_rd    = (REQ.op == fsb_pkg::OP_PORT_IN);
                  next_st.io.io_wr    = (REQ.op == fsb_pkg::OP_PORT_OUT);
                  next_st.io.io_wdata = REQ.operand;
                  // A plain write of all bits clears only the ones written as one.
                  next_st.w1c_mask    = (REQ.op == fsb_pkg::OP_PORT_OUT)
                                      ? (REQ.operand & IO_CLEAR_ON_ONE)
                                      : 8'h0_0;
                end else begin
                  // Port ops never reach the extended region.
                  next_st.access_error = 1'b1;
                end
              end
              fsb_pkg::OP_LOAD_DATA,
              fsb_pkg::OP_STORE_DATA: begin
                if (data_is_io) begin
                  next_st.io.io_addr  = data_io_addr;
                  next_st.io.io_rd    = (REQ.op == fsb_pkg::OP_LOAD_DATA);
                  next_st.io.io_wr    = (REQ.op == fsb_pkg::OP_STORE_DATA);
                  next_st.io.io_wdata = REQ.operand;
                  next_st.w1c_mask    = (REQ.op == fsb_pkg::OP_STORE_DATA)
                                      ? (REQ.operand & IO_CLEAR_ON_ONE)
                                      : 8'h0_0;
                end else if (data_is_ext) begin
                  next_st.io.ext_addr  = REQ.addr;
                  next_st.io.ext_rd    = (REQ.op == fsb_pkg::OP_LOAD_DATA);
                  next_st.io.ext_wr    = (REQ.op == fsb_pkg::OP_STORE_DATA);
                  next_st.io.ext_wdata = REQ.operand;
                end else begin
                  next_st.access_error = 1'b1;
                end
              end
              default: begin
                next_st.done = 1'b1;
              end
            endcase
            // A refused access answers with the error pulse alone, never with DONE.
            if (next_st.access_error) begin
              next_st.done = 1'b0;
            end
          end
        end
      end
      ST_IO_RMW: begin
        // Only the addressed bit is asserted in the clear mask, so other
        // pending clear-on-one flags in the register survive the write.
        next_st.io.io_wr    = 1'b1;
        next_st.io.io_addr  = st.held.addr[5:0];
        next_st.w1c_mask    = (st.held.op == fsb_pkg::OP_IO_BIT_SET)
                            ? (held_mask & IO_CLEAR_ON_ONE) : 8'h0_0;
        next_st.io.io_wdata = (st.held.op == fsb_pkg::OP_IO_BIT_SET)
                            ? (IO_RDATA | held_mask)
                            : (IO_RDATA & ~held_mask);
        next_st.done        = 1'b1;
        next_st.phase       = ST_IDLE;
      end
      ST_BRANCH: begin
        // PC_NEXT has stood since the take; the load marks the second cycle.
        next_st.pc_load = 1'b1;
        next_st.done    = 1'b1;
        next_st.phase   = ST_IDLE;
      end
      default: begin
        next_st.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st       <= '0;
      st.flags <= fsb_pkg::FLAGS_RESET;
      st.phase <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign REQ_READY    = (st.phase == ST_IDLE);
  assign DONE         = st.done;
  assign RESULT       = st.result;
  assign RESULT_VALID = st.result_valid;
  assign PC_LOAD      = st.pc_load;
  assign PC_NEXT      = st.pc_next;
  assign SKIP_NEXT    = st.skip_next;
  assign ACCESS_ERROR = st.access_error;
  assign STATUS_FLAGS = st.flags;
  assign IO_ACCESS    = st.io;
  assign IO_W1C_MASK  = st.w1c_mask;

endmodule : flag_shift_bitio_datapath
`default_nettype wire

/* fsb_checker_assertions.sv */
// Port checker for the flag, shift and I/O bit datapath.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module fsb_checker (
  input wire logic                CORE_CLK,
  input wire logic                RESET,
  input wire logic                REQ_VALID,
  input wire fsb_pkg::request_t   REQ,
  input wire logic                REQ_READY,
  input wire logic                DONE,
  input wire logic [7:0]          RESULT,
  input wire logic                RESULT_VALID,
  input wire logic                PC_LOAD,
  input wire logic [15:0]         PC_NEXT,
  input wire logic                SKIP_NEXT,
  input wire logic                ACCESS_ERROR,
  input wire logic [7:0]          STATUS_FLAGS,
  input wire fsb_pkg::io_access_t IO_ACCESS,
  input wire logic [7:0]          IO_W1C_MASK,
  input wire logic [7:0]          IO_RDATA,
  input wire logic [7:0]          IO_CLEAR_ON_ONE
);
  logic take;
  logic cond;
  logic [4:0] op;
  assign take = REQ_VALID && REQ_READY;
  assign op = REQ.op;
  // The branch condition is judged on the flags standing when the request is taken.
  always_comb begin
    case (op)
      5'h0_A:  cond = !STATUS_FLAGS[6];
      5'h0_B:  cond = STATUS_FLAGS[3];
      5'h0_C:  cond = !STATUS_FLAGS[3];
      5'h0_D:  cond = STATUS_FLAGS[7];
      5'h0_E:  cond = !STATUS_FLAGS[7];
      default: cond = 1'b0;
    endcase
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  bit_set_seq_a: assert property (take && op == 5'h0_F && REQ.addr <= 16'h0_01F
    |-> ##1 (IO_ACCESS.io_rd && !REQ_READY) ##1 (IO_ACCESS.io_wr && DONE
    && IO_ACCESS.io_wdata[$past(REQ.bit_sel, 2)])) else $error("io bit set sequence wrong");
  bit_clear_seq_a: assert property (take && op == 5'h1_0 && REQ.addr <= 16'h0_01F
    |-> ##2 (IO_ACCESS.io_wr && DONE && IO_W1C_MASK == 8'h0_0
    && !IO_ACCESS.io_wdata[$past(REQ.bit_sel, 2)])) else $error("io bit clear sequence wrong");
  bit_range_a: assert property (take && op inside {[5'h0_F:5'h1_2]} && REQ.addr > 16'h0_01F
    |=> ACCESS_ERROR && !DONE && !IO_ACCESS.io_wr) else $error("bit op above range accepted");
  port_map_a: assert property (take && op == 5'h1_4 && REQ.addr <= 16'h0_03F
    |=> IO_ACCESS.io_wr && IO_ACCESS.io_addr == $past(REQ.addr[5:0])) else $error("port write");
  data_map_a: assert property (take && op == 5'h1_6 && REQ.addr inside {[16'h0_020:16'h0_05F]}
    |=> IO_ACCESS.io_wr && {10'h0_00, IO_ACCESS.io_addr} == $past(REQ.addr) - 16'h0_020)
    else $error("data space io write misplaced");
  ext_map_a: assert property (take && op inside {5'h1_5, 5'h1_6}
    && REQ.addr inside {[16'h0_060:16'h0_0FF]} |=> (IO_ACCESS.ext_rd || IO_ACCESS.ext_wr)
    && IO_ACCESS.ext_addr == $past(REQ.addr) && !IO_ACCESS.io_wr) else $error("ext access");
  port_ext_a: assert property (take && op inside {5'h1_3, 5'h1_4} && REQ.addr > 16'h0_03F
    |=> ACCESS_ERROR && !IO_ACCESS.ext_rd && !IO_ACCESS.ext_wr) else $error("port reached ext");
  shift_flags_a: assert property (take && op inside {[5'h0_1:5'h0_5]} |=> DONE
    && RESULT_VALID && STATUS_FLAGS[1] == (RESULT == 8'h0_0) && STATUS_FLAGS[2] == RESULT[7]
    && STATUS_FLAGS[7:4] == $past(STATUS_FLAGS[7:4])) else $error("shift flags wrong");
  shift_ovf_a: assert property (take && op inside {[5'h0_1:5'h0_5]}
    |=> STATUS_FLAGS[3] == (STATUS_FLAGS[2] ^ STATUS_FLAGS[0])) else $error("shift overflow");
  right_carry_a: assert property (take && op inside {[5'h0_3:5'h0_5]}
    |=> STATUS_FLAGS[0] == $past(REQ.operand[0]) && RESULT[6:0] == $past(REQ.operand[7:1]))
    else $error("right shift carry wrong");
  branch_taken_a: assert property (take && cond |-> ##1 (!PC_LOAD && !DONE)
    ##1 (PC_LOAD && DONE
    && PC_NEXT == $past(REQ.pc, 2) + 16'(signed'($past(REQ.offset, 2))) + 16'h0_001))
    else $error("taken branch wrong");
  branch_fall_a: assert property (take && op inside {[5'h0_A:5'h0_E]} && !cond
    |=> DONE && !PC_LOAD) else $error("untaken branch wrong");
  flag_set_a: assert property (take && op == 5'h0_8 |=> DONE
    && STATUS_FLAGS == ($past(STATUS_FLAGS) | (8'h0_1 << $past(REQ.bit_sel))))
    else $error("indexed flag set wrong");
  bit_store_a: assert property (take && op == 5'h0_6
    |=> DONE && STATUS_FLAGS[6] == $past(REQ.operand[REQ.bit_sel])) else $error("bit store");
endmodule : fsb_checker
bind flag_shift_bitio_datapath fsb_checker chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ(REQ),
  .REQ_READY(REQ_READY), .DONE(DONE), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
  .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .SKIP_NEXT(SKIP_NEXT),
  .ACCESS_ERROR(ACCESS_ERROR), .STATUS_FLAGS(STATUS_FLAGS), .IO_ACCESS(IO_ACCESS),
  .IO_W1C_MASK(IO_W1C_MASK), .IO_RDATA(IO_RDATA), .IO_CLEAR_ON_ONE(IO_CLEAR_ON_ONE));
`default_nettype wire

/* fsb_io_model.sv */
// Model of the 64-register I/O space behind the datapath.
// Assumes one register at 0x1C holds clear-on-one flags in bits 0 and 4 to 7.
`timescale 1ns/1ns
`default_nettype none
module fsb_io_model (
  input  wire logic                CORE_CLK,
  input  wire logic                RESET,
  input  wire fsb_pkg::request_t   REQ,
  input  wire fsb_pkg::io_access_t IO_ACCESS,
  input  wire logic [7:0]          IO_W1C_MASK,
  output logic [7:0]               IO_RDATA,
  output logic [7:0]               IO_CLEAR_ON_ONE
);
  logic [7:0] regs [64];
  logic [5:0] sel;
  logic [5:0] req_io;
  logic [7:0] wcol;
  assign req_io = (REQ.op inside {fsb_pkg::OP_LOAD_DATA, fsb_pkg::OP_STORE_DATA})
                  ? 6'(REQ.addr - 16'h0_020) : REQ.addr[5:0];
  assign sel = IO_ACCESS.io_rd ? IO_ACCESS.io_addr : req_io;
  assign IO_RDATA = regs[sel];
  assign IO_CLEAR_ON_ONE = (sel == 6'h1_C) ? 8'hF_1 : 8'h0_0;
  assign wcol = (IO_ACCESS.io_addr == 6'h1_C) ? 8'hF_1 : 8'h0_0;
  // Flag bits ignore the written data and clear only where the mask says so.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int i = 0; i < 64; i++) regs[i] <= {i[5:0], 2'b01};
    end else if (IO_ACCESS.io_wr) begin
      regs[IO_ACCESS.io_addr] <= (IO_ACCESS.io_wdata & ~wcol)
                                 | (regs[IO_ACCESS.io_addr] & wcol & ~IO_W1C_MASK);
    end
  end
endmodule : fsb_io_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the flag, shift and I/O bit datapath.
// Assumes the I/O space model beside it and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                CORE_CLK;
  logic                RESET;
  logic                REQ_VALID;
  fsb_pkg::request_t   REQ;
  logic                REQ_READY;
  logic                DONE;
  logic                RESULT_VALID;
  logic                PC_LOAD;
  logic                SKIP_NEXT;
  logic                ACCESS_ERROR;
  logic [7:0]          RESULT;
  logic [7:0]          STATUS_FLAGS;
  logic [7:0]          IO_W1C_MASK;
  logic [7:0]          IO_RDATA;
  logic [7:0]          IO_CLEAR_ON_ONE;
  logic [15:0]         PC_NEXT;
  fsb_pkg::io_access_t IO_ACCESS;
  int                  n_fail = 0;
  int                  n_tests = 0;
  int                  cyc;
  logic [4:0]          got;
  logic [5:0]          io_addr;
  logic [7:0]          flags;
  logic [11:0]         expv;
  logic [7:0]          vals [3] = '{8'h8_1, 8'h8_0, 8'h0_1};
  int                  bflag [5] = '{6, 3, 3, 7, 7};
  int                  bwant [5] = '{0, 1, 0, 1, 0};
  fsb_pkg::op_t        dops [9] = '{fsb_pkg::OP_PORT_OUT, fsb_pkg::OP_PORT_OUT,
    fsb_pkg::OP_STORE_DATA, fsb_pkg::OP_PORT_IN, fsb_pkg::OP_LOAD_DATA,
    fsb_pkg::OP_STORE_DATA, fsb_pkg::OP_LOAD_DATA, fsb_pkg::OP_PORT_IN,
    fsb_pkg::OP_LOAD_DATA};
  logic [15:0]         daddr [9] = '{16'h0_03F, 16'h0_040, 16'h0_05F, 16'h0_060, 16'h0_060,
                                     16'h0_0FF, 16'h0_100, 16'h0_005, 16'h0_025};
  logic [8:0]          dexp [9] = '{9'h0_BF, 9'h1_00, 9'h0_BF, 9'h1_00,
                                    9'h0_40, 9'h0_40, 9'h1_00, 9'h0_85, 9'h0_85};

  flag_shift_bitio_datapath uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE), .RESULT(RESULT),
    .RESULT_VALID(RESULT_VALID), .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .SKIP_NEXT(SKIP_NEXT),
    .ACCESS_ERROR(ACCESS_ERROR), .STATUS_FLAGS(STATUS_FLAGS), .IO_ACCESS(IO_ACCESS),
    .IO_W1C_MASK(IO_W1C_MASK), .IO_RDATA(IO_RDATA), .IO_CLEAR_ON_ONE(IO_CLEAR_ON_ONE));
  fsb_io_model io (.CORE_CLK(CORE_CLK), .RESET(RESET), .REQ(REQ), .IO_ACCESS(IO_ACCESS),
    .IO_W1C_MASK(IO_W1C_MASK), .IO_RDATA(IO_RDATA), .IO_CLEAR_ON_ONE(IO_CLEAR_ON_ONE));

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Pulses are gathered over the whole answer, so cyc counts cycles to DONE or error.
  task automatic run(input fsb_pkg::op_t op, input logic [7:0] opnd, input logic [2:0] b,
                     input logic [15:0] addr, input logic signed [6:0] off);
    @(negedge CORE_CLK);
    REQ = '{op, opnd, b, addr, 16'h0_100, off};
    REQ_VALID = 1'b1;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
    got = '0;
    io_addr = '0;
    for (cyc = 1; cyc < 5; cyc++) begin
      got |= {ACCESS_ERROR, IO_ACCESS.io_rd | IO_ACCESS.io_wr,
              IO_ACCESS.ext_rd | IO_ACCESS.ext_wr, PC_LOAD, SKIP_NEXT};
      if (IO_ACCESS.io_rd | IO_ACCESS.io_wr) io_addr = IO_ACCESS.io_addr;
      if (DONE | ACCESS_ERROR) break;
      @(negedge CORE_CLK);
    end
  endtask : run

  function automatic logic [11:0] shift_ref(input int k, input logic [7:0] v, input logic c);
    logic [7:0] r;
    logic co;
    case (k)
      0:       {co, r} = {v, 1'b0};
      1:       {co, r} = {v, c};
      2:       {r, co} = {1'b0, v};
      3:       {r, co} = {c, v};
      default: {r, co} = {v[7], v};
    endcase
    return {r[7] ^ co, r[7], r == 8'h0_0, co, r};
  endfunction : shift_ref

  initial begin
    repeat (3000) @(posedge CORE_CLK);
    n_fail++;
    summarize();
  end

  initial begin
    RESET = 1'b1;
    REQ_VALID = 1'b0;
    REQ = '0;
    repeat (4) @(negedge CORE_CLK);
    RESET = 1'b0;
    check("flags_reset", STATUS_FLAGS, 8'h0_0);
    flags = 8'h0_0;
    for (int i = 0; i < 16; i++) begin
      run(i < 8 ? fsb_pkg::OP_FLAG_SET_INDEXED : fsb_pkg::OP_FLAG_CLEAR_INDEXED, 8'h0_0,
          3'(i), 16'h0_000, 7'sd0);
      flags[i % 8] = (i < 8);
      check("flag_index", STATUS_FLAGS, flags);
      check("flag_cycles", cyc, 1);
    end
    for (int k = 0; k < 30; k++) begin
      run((k / 3) % 2 ? fsb_pkg::OP_FLAG_SET_INDEXED : fsb_pkg::OP_FLAG_CLEAR_INDEXED, 8'h0_0,
          3'd0, 16'h0_000, 7'sd0);
      expv = shift_ref(k / 6, vals[k % 3], 1'((k / 3) % 2));
      run(fsb_pkg::op_t'(k / 6 + 1), vals[k % 3], 3'd0, 16'h0_000, 7'sd0);
      check("shift_result", RESULT, expv[7:0]);
      check("shift_flags", STATUS_FLAGS, {4'h0, expv[11:8]});
      check("shift_cycles", cyc, 1);
    end
    run(fsb_pkg::OP_TRANSFER_BIT_STORE, 8'h1_0, 3'd4, 16'h0_000, 7'sd0);
    check("t_store_one", STATUS_FLAGS[6], 1'b1);
    run(fsb_pkg::OP_TRANSFER_BIT_LOAD, 8'h0_0, 3'd2, 16'h0_000, 7'sd0);
    check("t_load_one", RESULT, 8'h0_4);
    run(fsb_pkg::OP_TRANSFER_BIT_STORE, 8'hE_F, 3'd4, 16'h0_000, 7'sd0);
    check("t_store_zero", STATUS_FLAGS[6], 1'b0);
    run(fsb_pkg::OP_TRANSFER_BIT_LOAD, 8'hF_F, 3'd0, 16'h0_000, 7'sd0);
    check("t_load_zero", RESULT, 8'hF_E);
    for (int k = 0; k < 10; k++) begin
      run(k % 2 ? fsb_pkg::OP_FLAG_SET_INDEXED : fsb_pkg::OP_FLAG_CLEAR_INDEXED, 8'h0_0,
          3'(bflag[k / 2]), 16'h0_000, 7'sd0);
      run(fsb_pkg::op_t'(k / 2 + 10), 8'h0_0, 3'd0, 16'h0_000, (k / 2) % 2 ? -7'sd3 : 7'sd63);
      check("branch_taken", got[1], 1'((k % 2) == bwant[k / 2]));
      check("branch_cycles", cyc, ((k % 2) == bwant[k / 2]) ? 2 : 1);
      if ((k % 2) == bwant[k / 2])
        check("branch_target", PC_NEXT, (k / 2) % 2 ? 16'h0_0FE : 16'h0_140);
    end
    run(fsb_pkg::OP_IO_BIT_SET, 8'h0_0, 3'd2, 16'h0_01C, 7'sd0);
    check("bit_set_cycles", cyc, 2);
    run(fsb_pkg::OP_SKIP_IF_IO_BIT_SET, 8'h0_0, 3'd2, 16'h0_01C, 7'sd0);
    check("skip_on_set", got[0], 1'b1);
    check("bit_set_reg", io.regs[28], 8'h7_5);
    run(fsb_pkg::OP_IO_BIT_CLEAR, 8'h0_0, 3'd2, 16'h0_01C, 7'sd0);
    check("bit_clear_cycles", cyc, 2);
    run(fsb_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 8'h0_0, 3'd2, 16'h0_01C, 7'sd0);
    check("skip_on_clear", got[0], 1'b1);
    check("bit_clear_reg", io.regs[28], 8'h7_1);
    run(fsb_pkg::OP_IO_BIT_SET, 8'h0_0, 3'd0, 16'h0_01C, 7'sd0);
    run(fsb_pkg::OP_SKIP_IF_IO_BIT_SET, 8'h0_0, 3'd0, 16'h0_01C, 7'sd0);
    check("flag_cleared", got[0], 1'b0);
    check("flag_reg", io.regs[28], 8'h7_0);
    run(fsb_pkg::OP_IO_BIT_SET, 8'h0_0, 3'd0, 16'h0_020, 7'sd0);
    check("bit_range", got[4:3], 2'b10);
    // Each port and data access is checked for its route (error, I/O or extended) and its I/O address.
    for (int k = 0; k < 9; k++) begin
      run(dops[k], 8'h5_A, 3'd0, daddr[k], 7'sd0);
      check("data_route", {got[4:2], io_addr}, dexp[k]);
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
